// *** core/cih_pkg.sv ***
package cih_pkg;

  // Register byte offsets on the APB window.
  localparam logic [11:0] CIH_CTRL_OFS = 12'h000;
  localparam logic [11:0] CIH_STATUS_OFS = 12'h004;
  localparam logic [11:0] CIH_CYCLES_OFS = 12'h008;
  localparam logic [11:0] CIH_TRAPS_OFS = 12'h00c;

  // Field positions and reset values.
  localparam int CIH_ATTACH_BIT = 0;
  localparam int CIH_ST_BUSY_BIT = 0;
  localparam int CIH_ST_CLS_LSB = 1;
  localparam int CIH_ST_UNDEF_BIT = 3;
  localparam int CIH_ST_ABORT_BIT = 4;
  localparam logic CIH_ATTACH_RST = 1'b0;

  // Instruction encoding constants.
  localparam logic [3:0] CIH_DATA_OP_PAT = 4'he;
  localparam logic [2:0] CIH_LOAD_STORE_PAT = 3'h6;
  localparam logic [3:0] CIH_PC_REG = 4'hf;
  localparam logic [31:0] CIH_PC_AHEAD = 32'h0000_0008;
  localparam logic [31:0] CIH_WORD_STEP = 32'h0000_0004;

  // Class of the instruction last executed.
  localparam logic [1:0] CIH_CLS_NONE = 2'h0;
  localparam logic [1:0] CIH_CLS_DATA_OP = 2'h1;
  localparam logic [1:0] CIH_CLS_XFER = 2'h2;

  typedef enum logic [2:0] {
    CIH_IDLE,
    CIH_WAIT,
    CIH_ISSUE,
    CIH_XFER,
    CIH_TAIL
  } cih_state_t;

  typedef struct packed {
    logic is_data_op;
    logic is_xfer;
    logic pre;
    logic up;
    logic long_len;
    logic write_back;
    logic load;
    logic [3:0] base_reg_field;
    logic [3:0] coproc_dest_reg;
    logic [3:0] coproc_number_field;
    logic [7:0] offset;
  } cih_instr_t;

  typedef struct packed {
    logic req;
    logic write;
    logic seq;
    logic [31:0] addr;
  } cih_mem_t;

  typedef struct packed {
    logic valid;
    logic [3:0] reg_idx;
    logic [31:0] data;
  } cih_wb_t;

endpackage

// *** core/cih_core.sv ***
// Design decisions made here: the APB interface to the registers and the register addresses.
`timescale 1ns/1ns
// Overview of operation
// RL1: No coprocessor fitted, so coprocessor instructions trap undefined.
// RL2: Execute only when condition field passes.
// RL3: Data operation: 1110 in 27:24, bit4 clear.
// RL4: Core reads only bit 4, bits 24-31.
// RL5: Data operation issued without waiting for result.
// RL6: Coprocessor answers only its own number.
// RL7: Data operation: one S plus busy I cycles.
// RL8: Load/store: 110 in 27:25, fields decoded.
// RL9: Bit 20 zero stores, one loads.
// RL10: Offset is imm shifted two, added or subtracted.
// RL11: Pre applies offset first, post afterwards.
// RL12: Write base back only when W set.
// RL13: Following words step address by four bytes.
// RL14: Core gives addresses, coprocessor gives data, count.
// RL15: Low two address bits passed unaltered.
// RL16: PC base is instruction address plus eight.
// RL17: Abort traps, still writes base back.
// RL18: Coprocessor keeps aborted transfer restartable.
// RL19: Transfer: (n-1) S, two N, busy I cycles.
// RL20: Coprocessor uses register field and length bit.
// RL21: Software should give word-aligned base.
// RL22: Undefined trap issues no access nor write-back.
module cih_core import cih_pkg::*; (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic instr_valid,
  output logic instr_ready,
  input wire logic [31:0] instr_word,
  input wire logic [31:0] instr_addr,
  input wire logic [3:0] cpsr_flags,
  input wire logic [31:0] base_value,
  input wire logic cop_busy,
  input wire logic cop_last,
  output logic cop_issue,
  output logic [31:0] cop_instr,
  input wire logic mem_abort,
  output cih_mem_t mem_out,
  output cih_wb_t wb_out,
  output logic undef_trap,
  output logic abort_trap
);
  function automatic logic cond_pass(input logic [3:0] c, input logic [3:0] f);
    // Flags arrive as {N,Z,C,V}, so f[3] is N and f[0] is V.
    case (c)
      4'h0: cond_pass = f[2];
      4'h1: cond_pass = !f[2];
      4'h2: cond_pass = f[1];
      4'h3: cond_pass = !f[1];
      4'h4: cond_pass = f[3];
      4'h5: cond_pass = !f[3];
      4'h6: cond_pass = f[0];
      4'h7: cond_pass = !f[0];
      4'h8: cond_pass = f[1] && !f[2];
      4'h9: cond_pass = !f[1] || f[2];
      4'ha: cond_pass = f[3] == f[0];
      4'hb: cond_pass = f[3] != f[0];
      4'hc: cond_pass = !f[2] && (f[3] == f[0]);
      4'hd: cond_pass = f[2] || (f[3] != f[0]);
      4'he: cond_pass = 1'b1;
      default: cond_pass = 1'b0;
    endcase
  endfunction
  function automatic cih_instr_t decode(input logic [31:0] w);
    cih_instr_t d;
    d.is_data_op = (w[27:24] == CIH_DATA_OP_PAT) && !w[4]; // [RL3] [RL4]
    d.is_xfer = w[27:25] == CIH_LOAD_STORE_PAT; // [RL8]
    d.pre = w[24];
    d.up = w[23];
    d.long_len = w[22];
    d.write_back = w[21];
    d.load = w[20];
    d.base_reg_field = w[19:16];
    d.coproc_dest_reg = w[15:12];
    d.coproc_number_field = w[11:8];
    d.offset = w[7:0];
    decode = d;
  endfunction
  function automatic logic [31:0] apply_offset(input logic [31:0] b, input logic up,
                                               input logic [7:0] imm);
    logic [31:0] ofs;
    ofs = {22'h0, imm, 2'h0};
    apply_offset = up ? b + ofs : b - ofs; // [RL10]
  endfunction

  cih_state_t st_r;
  cih_instr_t dec;
  logic attach_r;
  logic [31:0] ins_r;
  logic [31:0] base_r;
  logic [31:0] modbase_r;
  logic wb_en_r;
  logic abt_r;
  logic [31:0] cyc_r;
  logic [31:0] cycles_r;
  logic [31:0] traps_r;
  logic [1:0] cls_r;
  logic undef_seen_r;
  logic abort_seen_r;
  logic take;
  logic is_cop;
  logic pass;
  logic go;
  logic [31:0] eff_base;
  logic [31:0] eff_mod;
  logic apb_wr;
  logic apb_rd;
  logic mapped;

  ////////////////////////////////////////////////////////////////////////////
  // Instruction acceptance and address generation.
  assign dec = decode(instr_word);
  assign instr_ready = st_r == CIH_IDLE;
  assign take = ce && instr_valid && instr_ready;
  assign is_cop = dec.is_data_op || dec.is_xfer;
  assign pass = cond_pass(instr_word[31:28], cpsr_flags); // [RL2]
  assign go = take && is_cop && pass;
  assign eff_base = (dec.base_reg_field == CIH_PC_REG) ? instr_addr + CIH_PC_AHEAD
                                                       : base_value; // [RL16]
  assign eff_mod = apply_offset(eff_base, dec.up, dec.offset);

  always_ff @(posedge clk) begin
    if (rst) begin
      st_r <= CIH_IDLE;
      ins_r <= 32'h0;
      base_r <= 32'h0;
      modbase_r <= 32'h0;
      wb_en_r <= 1'b0;
      abt_r <= 1'b0;
      cyc_r <= 32'h0;
    end else if (ce) begin
      case (st_r)
        CIH_IDLE: begin
          // Detached, the instruction goes to the trap handler untouched.
          if (go && attach_r) begin // [RL1] [RL22]
            st_r <= CIH_WAIT;
            ins_r <= instr_word;
            base_r <= eff_base;
            modbase_r <= eff_mod;
            // Write-back into the program counter is never performed.
            wb_en_r <= dec.is_xfer && dec.write_back &&
                       (dec.base_reg_field != CIH_PC_REG); // [RL12] [RL16]
            abt_r <= 1'b0;
            cyc_r <= 32'h0;
          end
        end
        CIH_WAIT: begin
          if (cop_busy) begin
            cyc_r <= cyc_r + 32'h1; // [RL7] [RL19]
          end else if (ins_r[27:25] == CIH_LOAD_STORE_PAT) begin
            st_r <= CIH_XFER;
          end else begin
            st_r <= CIH_ISSUE;
          end
        end
        CIH_ISSUE: begin
          // The data operation is handed over and not waited for.
          st_r <= CIH_IDLE; // [RL5]
          cyc_r <= cyc_r + 32'h1; // [RL7]
        end
        CIH_XFER: begin
          cyc_r <= cyc_r + 32'h1; // [RL19]
          // The coprocessor ends the transfer, the memory manager may abort it.
          if (mem_abort || cop_last) begin // [RL14]
            st_r <= CIH_TAIL;
            abt_r <= mem_abort;
          end
        end
        CIH_TAIL: begin
          st_r <= CIH_IDLE;
          cyc_r <= cyc_r + 32'h1; // [RL19]
        end
        default: st_r <= CIH_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Memory address sequencing.
  always_ff @(posedge clk) begin
    if (rst) begin
      mem_out <= '0;
    end else if (ce) begin
      if (st_r == CIH_WAIT && !cop_busy && ins_r[27:25] == CIH_LOAD_STORE_PAT) begin
        mem_out.req <= 1'b1;
        mem_out.write <= !ins_r[20]; // [RL9]
        mem_out.seq <= 1'b0;
        // Low address bits are left as computed.
        mem_out.addr <= ins_r[24] ? modbase_r : base_r; // [RL11] [RL15]
      end else if (st_r == CIH_XFER && !mem_abort && !cop_last) begin
        mem_out.seq <= 1'b1;
        mem_out.addr <= mem_out.addr + CIH_WORD_STEP; // [RL13]
      end else begin
        mem_out.req <= 1'b0;
        mem_out.seq <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Coprocessor issue, base write-back and traps.
  always_ff @(posedge clk) begin
    if (rst) begin
      cop_issue <= 1'b0;
      cop_instr <= 32'h0;
    end else if (ce) begin
      cop_issue <= (st_r == CIH_WAIT) && !cop_busy;
      if (st_r == CIH_WAIT && !cop_busy) begin
        cop_instr <= ins_r;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wb_out <= '0;
      abort_trap <= 1'b0;
      undef_trap <= 1'b0;
    end else if (ce) begin
      // Write-back is kept even when the transfer aborted.
      wb_out.valid <= (st_r == CIH_TAIL) && wb_en_r; // [RL12] [RL17]
      wb_out.reg_idx <= ins_r[19:16];
      wb_out.data <= modbase_r;
      abort_trap <= (st_r == CIH_TAIL) && abt_r; // [RL17]
      undef_trap <= go && !attach_r; // [RL1] [RL22]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB register file.
  assign pready = 1'b1;
  assign mapped = paddr == CIH_CTRL_OFS || paddr == CIH_STATUS_OFS ||
                  paddr == CIH_CYCLES_OFS || paddr == CIH_TRAPS_OFS;
  assign pslverr = psel && penable && !mapped;
  assign apb_wr = psel && penable && pwrite && mapped;
  assign apb_rd = psel && !penable && !pwrite;

  always_ff @(posedge clk) begin
    if (rst) begin
      attach_r <= CIH_ATTACH_RST;
    end else if (ce && apb_wr && paddr == CIH_CTRL_OFS) begin
      attach_r <= pwdata[CIH_ATTACH_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cycles_r <= 32'h0;
      traps_r <= 32'h0;
      cls_r <= CIH_CLS_NONE;
      undef_seen_r <= 1'b0;
      abort_seen_r <= 1'b0;
    end else if (ce) begin
      if (st_r == CIH_ISSUE || st_r == CIH_TAIL) begin
        cycles_r <= cyc_r + 32'h1;
      end
      if (go) begin
        cls_r <= dec.is_xfer ? CIH_CLS_XFER : CIH_CLS_DATA_OP;
        undef_seen_r <= !attach_r;
        abort_seen_r <= 1'b0;
      end else if (st_r == CIH_TAIL && abt_r) begin
        abort_seen_r <= 1'b1;
      end
      // A software write clears the trap count; a trap in the same cycle is counted after the clear, leaving one.
      if (go && !attach_r) begin
        traps_r <= (apb_wr && paddr == CIH_TRAPS_OFS) ? 32'h1 : traps_r + 32'h1;
      end else if (apb_wr && paddr == CIH_TRAPS_OFS) begin
        traps_r <= 32'h0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      prdata <= 32'h0;
    end else if (ce && apb_rd) begin
      prdata <= 32'h0;
      case (paddr)
        CIH_CTRL_OFS: prdata[CIH_ATTACH_BIT] <= attach_r;
        CIH_STATUS_OFS: begin
          prdata[CIH_ST_BUSY_BIT] <= st_r != CIH_IDLE;
          prdata[CIH_ST_CLS_LSB +: 2] <= cls_r;
          prdata[CIH_ST_UNDEF_BIT] <= undef_seen_r;
          prdata[CIH_ST_ABORT_BIT] <= abort_seen_r;
        end
        CIH_CYCLES_OFS: prdata <= cycles_r;
        CIH_TRAPS_OFS: prdata <= traps_r;
        default: prdata <= 32'h0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks. Helper counters track busy cycles and words independently.
  logic [31:0] hb_r;
  logic [31:0] hw_r;
  always_ff @(posedge clk) begin
    if (rst) begin
      hb_r <= 32'h0;
      hw_r <= 32'h0;
    end else if (ce) begin
      if (st_r == CIH_IDLE) begin
        hb_r <= 32'h0;
        hw_r <= 32'h0;
      end else begin
        hb_r <= hb_r + {31'h0, st_r == CIH_WAIT && cop_busy};
        hw_r <= hw_r + {31'h0, mem_out.req};
      end
    end
  end

  AST_UNDEF_WHEN_DETACHED: assert property (@(posedge clk) disable iff (rst) // [RL1]
    go && !attach_r |=> undef_trap && st_r == CIH_IDLE)
    else $error("detached coprocessor instruction did not trap");
  AST_COND_FAIL_IGNORED: assert property (@(posedge clk) disable iff (rst) // [RL2]
    take && is_cop && !pass |=> st_r == CIH_IDLE && !undef_trap)
    else $error("instruction with failing condition had an effect");
  AST_NO_ACCESS_ON_TRAP: assert property (@(posedge clk) disable iff (rst) // [RL22]
    undef_trap |-> !mem_out.req && !wb_out.valid && !cop_issue)
    else $error("undefined trap came with an access");
  AST_DATA_OP_NO_STALL: assert property (@(posedge clk) disable iff (rst) // [RL5]
    st_r == CIH_ISSUE && ce |-> cop_issue ##1 st_r == CIH_IDLE)
    else $error("data operation waited for completion");
  AST_DATA_OP_CYCLES: assert property (@(posedge clk) disable iff (rst) // [RL7]
    st_r == CIH_ISSUE && ce |=> cycles_r == $past(hb_r) + 32'h1)
    else $error("data operation cycle count wrong");
  AST_XFER_CYCLES: assert property (@(posedge clk) disable iff (rst) // [RL19]
    st_r == CIH_TAIL && ce |=> cycles_r == $past(hb_r) + $past(hw_r) + 32'h1)
    else $error("transfer cycle count wrong");
  AST_FIRST_ADDR: assert property (@(posedge clk) disable iff (rst) // [RL11]
    mem_out.req && !mem_out.seq |-> mem_out.addr == (ins_r[24] ? modbase_r : base_r))
    else $error("first transfer address wrong");
  AST_ADDR_STEP: assert property (@(posedge clk) disable iff (rst) // [RL13]
    st_r == CIH_XFER && ce && !mem_abort && !cop_last
    |=> mem_out.seq && mem_out.addr == $past(mem_out.addr) + CIH_WORD_STEP)
    else $error("following word address not four bytes higher");
  AST_DIRECTION: assert property (@(posedge clk) disable iff (rst) // [RL9]
    mem_out.req |-> mem_out.write == !ins_r[20])
    else $error("transfer direction wrong");
  AST_WB_VALUE: assert property (@(posedge clk) disable iff (rst) // [RL10]
    wb_out.valid |-> wb_out.data == (ins_r[23] ? base_r + {22'h0, ins_r[7:0], 2'h0}
                                                : base_r - {22'h0, ins_r[7:0], 2'h0}))
    else $error("written back base wrong");
  AST_WB_ONLY_W: assert property (@(posedge clk) disable iff (rst) // [RL12]
    wb_out.valid |-> ins_r[21] && ins_r[19:16] != CIH_PC_REG)
    else $error("write-back without W bit");
  AST_ABORT_KEEPS_WB: assert property (@(posedge clk) disable iff (rst) // [RL17]
    st_r == CIH_XFER && ce && mem_abort ##1 ce[*1]
    |=> abort_trap && wb_out.valid == (ins_r[21] && ins_r[19:16] != CIH_PC_REG))
    else $error("abort did not trap or lost write-back");
  CVR_DATA_OP: cover property (@(posedge clk) disable iff (rst)
    st_r == CIH_ISSUE ##1 st_r == CIH_IDLE);
  CVR_MULTI_WORD: cover property (@(posedge clk) disable iff (rst)
    mem_out.req && mem_out.seq ##1 mem_out.req && mem_out.seq);
  CVR_ABORT: cover property (@(posedge clk) disable iff (rst) abort_trap);
  CVR_UNDEF: cover property (@(posedge clk) disable iff (rst) undef_trap);
endmodule

// *** verification/cih_cop_model.sv ***
`timescale 1ns/1ns
module cih_cop_model import cih_pkg::*; #(
  parameter logic [3:0] OWN_NUM = 4'h5,
  parameter logic [3:0] LONG_WORDS = 4'h3
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic instr_valid,
  input wire logic instr_ready,
  input wire logic [31:0] instr_word,
  input wire logic [3:0] busy_len,
  input wire logic [3:0] abort_at,
  input wire cih_mem_t mem_out,
  output logic cop_busy,
  output logic cop_last,
  output logic mem_abort
);
  logic [3:0] busy_r;
  logic [3:0] word_r;
  logic [3:0] n_r;
  logic mine_r;
  logic take;

  assign take = instr_valid & instr_ready & ce;

  // Busy runs only for an instruction that carries this unit's number.
  always_ff @(posedge clk) begin
    if (rst) begin
      busy_r <= 4'h0;
    end else if (take && instr_word[11:8] == OWN_NUM) begin
      busy_r <= busy_len;
    end else if (ce && busy_r != 4'h0) begin
      busy_r <= busy_r - 4'h1;
    end
  end

  // Counters restart with every instruction, so a retried transfer repeats exactly.
  always_ff @(posedge clk) begin
    if (rst) begin
      word_r <= 4'h0;
      n_r <= 4'h1;
      mine_r <= 1'b0;
    end else if (take) begin
      word_r <= 4'h0;
      n_r <= instr_word[22] ? LONG_WORDS : 4'h1;
      mine_r <= instr_word[11:8] == OWN_NUM;
    end else if (ce && mem_out.req) begin
      word_r <= word_r + 4'h1;
    end
  end

  assign cop_busy = busy_r != 4'h0;
  assign cop_last = mem_out.req & mine_r & (word_r == n_r - 4'h1);
  assign mem_abort = mem_out.req & (word_r == abort_at);
endmodule

// *** verification/testbench.sv ***
`timescale 1ns/1ns
module testbench import cih_pkg::*;;
  typedef struct packed {
    logic [31:0] w, a, b;
    logic [3:0] bz, ab;
    logic [31:0] xa;
    logic [3:0] xn;
    logic xi, xu, xab, xwv;
    logic [31:0] xwb, xc;
  } cih_row_t;

  logic clk, rst, ce, psel, penable, pwrite, instr_valid, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, instr_word, instr_addr, base_value, prdata, cop_instr, q;
  logic pready, pslverr, instr_ready, cop_busy, cop_last, cop_issue, mem_abort;
  logic undef_trap, abort_trap;
  logic [3:0] cpsr_flags, busy_len, abort_at;
  cih_mem_t mem_out;
  cih_wb_t wb_out;
  cih_row_t r;
  cih_row_t rows [7];
  int bad_count, n_compared, traps;

  cih_core u_dut (.clk(clk), .rst(rst), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .instr_valid(instr_valid), .instr_ready(instr_ready),
    .instr_word(instr_word), .instr_addr(instr_addr), .cpsr_flags(cpsr_flags),
    .base_value(base_value), .cop_busy(cop_busy), .cop_last(cop_last),
    .cop_issue(cop_issue), .cop_instr(cop_instr), .mem_abort(mem_abort),
    .mem_out(mem_out), .wb_out(wb_out), .undef_trap(undef_trap), .abort_trap(abort_trap));

  cih_cop_model u_cop (.clk(clk), .rst(rst), .ce(ce), .instr_valid(instr_valid),
    .instr_ready(instr_ready), .instr_word(instr_word), .busy_len(busy_len),
    .abort_at(abort_at), .mem_out(mem_out), .cop_busy(cop_busy), .cop_last(cop_last),
    .mem_abort(mem_abort));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("Compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: flag %b expected %b", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      chk1(1'b0, 1'b1);
      test_done();
    end
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic xe);
    apb(1'b0, a, 32'h0);
    chk(q, x);
    chk1(e, xe);
  endtask

  // Condition table indexed by the top nibble; flags are {N,Z,C,V}.
  function automatic logic cond_ok(input logic [3:0] c, input logic [3:0] f);
    logic [15:0] t;
    t = {1'b0, 1'b1, f[2] | (f[3] != f[0]), !f[2] & (f[3] == f[0]), f[3] != f[0],
      f[3] == f[0], !f[1] | f[2], f[1] & !f[2], !f[0], f[0], !f[3], f[3], !f[1], f[1],
      !f[2], f[2]};
    return t[c];
  endfunction

  task automatic run(input cih_row_t r, input logic [3:0] fl);
    int k, n, rdy, iss, ud, ab, wbn;
    @(posedge clk);
    instr_valid <= 1'b1;
    instr_word <= r.w;
    instr_addr <= r.a;
    base_value <= r.b;
    cpsr_flags <= fl;
    busy_len <= r.bz;
    abort_at <= r.ab;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (instr_ready !== 1'b1 && n < 50);
    instr_valid <= 1'b0;
    {k, rdy, iss, ud, ab, wbn} = '0;
    for (n = 0; n < 80 && rdy < 2; n++) begin
      #1;
      if (mem_out.req === 1'b1) begin
        chk(mem_out.addr, r.xa + 32'(4 * k));
        chk1(mem_out.seq, k != 0);
        chk1(mem_out.write, !r.w[20]);
        k++;
      end
      if (cop_issue === 1'b1) begin
        iss++;
        chk(cop_instr, r.w);
      end
      if (wb_out.valid === 1'b1) begin
        wbn++;
        chk(wb_out.data, r.xwb);
        chk({28'h0, wb_out.reg_idx}, {28'h0, r.w[19:16]});
      end
      ud += int'(undef_trap === 1'b1);
      ab += int'(abort_trap === 1'b1);
      rdy += int'(instr_ready === 1'b1);
      @(posedge clk);
    end
    if (rdy < 2) begin
      chk1(1'b0, 1'b1);
      test_done();
    end
    chk(32'(k), {28'h0, r.xn});
    chk(32'(iss), {31'h0, r.xi});
    chk(32'(ud), {31'h0, r.xu});
    chk(32'(ab), {31'h0, r.xab});
    chk(32'(wbn), {31'h0, r.xwv});
  endtask

  initial begin
    repeat (100000) @(posedge clk);
    chk1(1'b0, 1'b1);
    test_done();
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {rst, ce} = 2'h3;
    {psel, penable, pwrite, instr_valid} = 4'h0;
    {paddr, pwdata, instr_word, instr_addr, base_value} = '0;
    {cpsr_flags, busy_len, abort_at} = 12'h00f;
    {bad_count, n_compared, traps} = '0;
    rows[0] = {96'h0, 8'h2f, 32'h0, 8'h08, 32'h0, 32'h3};
    rows[0].w = 32'hee123543;
    rows[1] = {32'heda31510, 32'h0, 32'h1000, 8'h0f, 32'h1040, 8'h19, 32'h1040, 32'h2};
    rows[2] = {32'hec722503, 32'h0, 32'h2002, 8'h1f, 32'h2002, 8'h39, 32'h1ff6, 32'h5};
    rows[3] = {32'heddf0502, 32'h100, 32'h5555, 8'h01, 32'h110, 8'h2a, 32'h0, 32'h3};
    rows[4] = {32'hed247501, 32'h0, 32'h3000, 8'h30, 32'h2ffc, 8'h1b, 32'h2ffc, 32'h5};
    rows[5] = {32'hee123643, 64'h0, 8'h4f, 32'h0, 8'h08, 32'h0, 32'h1};
    rows[6] = {32'h0da31510, 64'h0, 8'h0f, 32'h0, 8'h00, 32'h0, 32'hffffffff};
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    chk1(instr_ready, 1'b1);
    chk1(undef_trap, 1'b0);
    rd(CIH_CTRL_OFS, 32'h0, 1'b0);
    rd(CIH_TRAPS_OFS, 32'h0, 1'b0);
    rd(12'h010, 32'h0, 1'b1);
    apb(1'b1, 12'h010, 32'h1);
    rd(CIH_CTRL_OFS, 32'h0, 1'b0);
    $display("test reset done");
    apb(1'b1, CIH_CTRL_OFS, 32'h1);
    rd(CIH_CTRL_OFS, 32'h1, 1'b0);
    foreach (rows[i]) begin
      run(rows[i], 4'h0);
      if (rows[i].xc !== 32'hffffffff) begin
        rd(CIH_CYCLES_OFS, rows[i].xc, 1'b0);
      end
      $display("test row %0d done", i);
    end
    // The failing-condition row leaves the class of the data operation before it.
    rd(CIH_STATUS_OFS, 32'h0000_0002, 1'b0);
    // With the clock enable low a control write must not land.
    ce <= 1'b0;
    apb(1'b1, CIH_CTRL_OFS, 32'h0);
    ce <= 1'b1;
    rd(CIH_CTRL_OFS, 32'h1, 1'b0);
    $display("test freeze done");
    // With no unit attached every passing coprocessor word must trap.
    apb(1'b1, CIH_CTRL_OFS, 32'h0);
    for (int i = 0; i < 32; i++) begin
      r = '0;
      r.w = {i[3:0], i[4] ? 28'hda31510 : 28'he123543};
      r.xu = cond_ok(i[3:0], i[4] ? 4'hb : 4'h4);
      traps += int'(r.xu);
      run(r, i[4] ? 4'hb : 4'h4);
    end
    r = '0;
    r.w = 32'he1a00000;
    run(r, 4'h0);
    rd(CIH_TRAPS_OFS, 32'(traps), 1'b0);
    rd(CIH_STATUS_OFS, 32'h0000_000c, 1'b0);
    apb(1'b1, CIH_TRAPS_OFS, 32'h0);
    rd(CIH_TRAPS_OFS, 32'h0, 1'b0);
    $display("test trap done");
    test_done();
  end
endmodule
